// ---- inc/uart_regs.vh ----
`ifndef UART_REGS_VH
`define UART_REGS_VH
// Byte offsets on the register bus
`define ADDR_BAUD   8'h00
`define ADDR_CTRL1  8'h04
`define ADDR_CTRL2  8'h08
`define ADDR_STAT1  8'h0C
`define ADDR_STAT2  8'h10
`define ADDR_CTRL3  8'h14
`define ADDR_DATA   8'h18
`define ADDR_CTRL4  8'h1C
// Control 1 fields
`define C1_PAR_ODD  0
`define C1_PAR_EN   1
`define C1_IDLE_TYP 2
`define C1_WAKE_SEL 3
`define C1_NINE     4
`define C1_RX_SRC   5
`define C1_LOOP     7
// Control 2 fields
`define C2_SLEEP    1
`define C2_RX_EN    2
`define C2_TX_EN    3
`define C2_IDLE_IE  4
`define C2_FULL_IE  5
`define C2_TC_IE    6
`define C2_EMPTY_IE 7
// Status 2 fields
`define S2_RX_BUSY  0
`define S2_IDLE_RPT 3
`define S2_EDGE     6
`define S2_BREAK    7
// Control 3 fields, bits 3:0 enable overrun, noise, framing, parity
`define C3_TX_DIR   5
`define C3_TX_NINTH 6
// Control 4 fields
`define C4_EDGE_IE  0
`define C4_BREAK_IE 1
// Reset values
`define BAUD_RST    13'h0001
`define CTRL_RST    8'h00
// Character length in bit times, 16x phase figures
`define CHAR_BITS8  4'hA
`define CHAR_BITS9  4'hB
`define LAST_PH     4'hF
`define EVAL_PH     4'hA
`endif

// ---- hw/uart_tx_shift.v ----
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module uart_tx_shift
(
  // Clock, reset, 16x enable
  input  wire        aclk,
  input  wire        rst,
  input  wire        tick16,
  // Frame to send, LSB first
  input  wire        load,
  input  wire [11:0] frame,
  input  wire [3:0]  nbits,
  // Line
  output wire        busy,
  output reg         txd_r
);
  reg [11:0] sh_r;
  reg [3:0]  left_r;
  reg [3:0]  ph_r;

  assign busy = (left_r != 4'h0);

  always @(posedge aclk)
  begin
    if (rst)
    begin
      sh_r   <= 12'hFFF;
      left_r <= 4'h0;
      ph_r   <= 4'h0;
      txd_r  <= 1'b1;
    end
    else if (load && !busy)
    begin
      sh_r   <= frame;
      left_r <= nbits;
      ph_r   <= 4'h0;
      txd_r  <= frame[0];
    end
    else if (busy && tick16)
    begin
      ph_r <= ph_r + 4'h1;
      if (ph_r == `LAST_PH)
      begin
        sh_r   <= {1'b1, sh_r[11:1]};
        left_r <= left_r - 4'h1;
        // Line returns to idle high once the last bit is out
        txd_r  <= (left_r == 4'h1) ? 1'b1 : sh_r[1];
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/uart_rx_shift.v ----
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module uart_rx_shift
(
  // Clock, reset, 16x enable
  input  wire       aclk,
  input  wire       rst,
  input  wire       tick16,
  // Line and format
  input  wire       rx_in,
  input  wire       nine,
  input  wire       par_en,
  input  wire       par_odd,
  // Per-bit view for idle counting
  output reg        bit_tick_r,
  output reg        bit_val_r,
  output wire       in_frame,
  // Character results
  output reg        msb_set_r,
  output reg        done_r,
  output reg  [8:0] data_r,
  output reg        noise_r,
  output reg        frame_err_r,
  output reg        par_err_r
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA  = 2'h2;
  localparam ST_STOP  = 2'h3;

  reg [1:0] st_r;
  reg [3:0] ph_r;
  reg [3:0] cnt_r;
  reg [2:0] smp_r;
  reg [8:0] sh_r;
  reg       prev_r;
  reg       nz_r;
  reg       px_r;
  wire      maj  = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);
  wire      nzy  = (smp_r != 3'h0) && (smp_r != 3'h7);
  wire      eval = tick16 && (ph_r == `EVAL_PH);
  wire [3:0] last = nine ? 4'h8 : 4'h7;

  assign in_frame = (st_r != ST_IDLE);

  always @(posedge aclk)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE; ph_r <= 4'h0; cnt_r <= 4'h0; smp_r <= 3'h7;
      sh_r <= 9'h000; prev_r <= 1'b0; nz_r <= 1'b0; px_r <= 1'b0;
      bit_tick_r <= 1'b0; bit_val_r <= 1'b1; msb_set_r <= 1'b0; done_r <= 1'b0;
      data_r <= 9'h000; noise_r <= 1'b0; frame_err_r <= 1'b0; par_err_r <= 1'b0;
    end
    else
    begin
      bit_tick_r <= eval;
      bit_val_r  <= maj;
      msb_set_r  <= 1'b0;
      done_r     <= 1'b0;
      if (tick16)
      begin
        ph_r <= ph_r + 4'h1;
        if ((ph_r >= 4'h7) && (ph_r <= 4'h9))
          smp_r <= {smp_r[1:0], rx_in};
      end
      case (st_r)
        ST_IDLE:
          if (tick16)
          begin
            prev_r <= rx_in;
            if (prev_r && !rx_in)
            begin
              st_r <= ST_START;
              ph_r <= 4'h1;
              px_r <= 1'b0;
            end
          end
        ST_START:
          if (eval)
          begin
            // A start bit that votes high was a glitch
            st_r  <= maj ? ST_IDLE : ST_DATA;
            cnt_r <= 4'h0;
            nz_r  <= nzy;
          end
        ST_DATA:
          if (eval)
          begin
            sh_r  <= {maj, sh_r[8:1]};
            px_r  <= px_r ^ maj;
            nz_r  <= nz_r | nzy;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == last)
            begin
              st_r      <= ST_STOP;
              msb_set_r <= maj;
            end
          end
        ST_STOP:
          if (eval)
          begin
            st_r        <= ST_IDLE;
            prev_r      <= maj;
            done_r      <= 1'b1;
            data_r      <= nine ? sh_r : {1'b0, sh_r[8:1]};
            noise_r     <= nz_r | nzy;
            frame_err_r <= ~maj;
            par_err_r   <= par_en & (px_r ^ par_odd);
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hw/uart_core.v ----
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module uart_core
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Register bus, write side
  input  wire        awvalid,
  output reg         awready,
  input  wire [7:0]  awaddr,
  input  wire        wvalid,
  output reg         wready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  output reg         bvalid,
  input  wire        bready,
  output reg  [1:0]  bresp,
  // Register bus, read side
  input  wire        arvalid,
  output reg         arready,
  input  wire [7:0]  araddr,
  output reg         rvalid,
  input  wire        rready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  // Serial pins
  input  wire        rxd_i,
  input  wire        txd_i,
  output reg         txd_o,
  output reg         txd_oe,
  output reg         rx_pin_used,
  // Power modes
  input  wire        stop_light,
  input  wire        stop_deep,
  // Requests
  output reg         irq_tx,
  output reg         irq_rx,
  output reg         irq_err,
  output reg         wakeup
);

////////////////////////////////////////////////////////////////////////////////

  function [11:0] mk_frame;
    input [7:0] d;
    input       n9;
    input       nine;
    input       pe;
    input       po;
    reg         p7;
    reg         p8;
    begin
      p7 = (^d[6:0]) ^ po;
      p8 = (^d) ^ po;
      if (nine)
        mk_frame = {2'b11, pe ? p8 : n9, d, 1'b0};
      else
        mk_frame = {3'b111, pe ? p7 : d[7], d[6:0], 1'b0};
    end
  endfunction

  // Deep stop wipes the block; light stop only freezes the bit clock and bus
  wire rst_i = ~aresetn | stop_deep;
  wire ce    = ~stop_light;

  reg [12:0] baud_r;
  reg [12:0] div_cnt_r;
  reg        tick_r;
  reg [7:0]  ctrl1_r;
  reg [7:0]  ctrl2_r;
  reg [6:0]  ctrl3_r;
  reg [1:0]  ctrl4_r;
  reg        idle_rpt_r;
  reg        sleep_r;
  reg        rx_full_flag_r;
  reg        idle_r;
  reg        or_r;
  reg        nf_r;
  reg        fe_r;
  reg        pf_r;
  reg        edge_r;
  reg        brk_r;
  reg        tc_r;
  reg [5:0]  arm_r;
  reg        idle_ok_r;
  reg [3:0]  idle_cnt_r;
  reg [7:0]  rx_data_r;
  reg        rx_ninth_r;
  reg [7:0]  tx_buf_r;
  reg        tx_full_r;
  reg        pre_pend_r;
  reg        te_prev_r;
  reg        rxd_m_r;
  reg        rxd_s_r;
  reg        txi_m_r;
  reg        txi_s_r;
  reg        rx_prev_r;
  reg [31:0] rdata_nxt;

  wire       nine     = ctrl1_r[`C1_NINE];
  wire       loop     = ctrl1_r[`C1_LOOP];
  wire       src      = ctrl1_r[`C1_RX_SRC];
  wire       re       = ctrl2_r[`C2_RX_EN];
  wire       te       = ctrl2_r[`C2_TX_EN];
  wire       dir      = ctrl3_r[`C3_TX_DIR];
  wire [3:0] char_len = nine ? `CHAR_BITS9 : `CHAR_BITS8;

////////////////////////////////////////////////////////////////////////////////
// Pins and line selection

  wire txs_busy;
  wire txs_txd;
  wire single   = loop & src;
  // Receiver source: pin, internal loop, or the shared transmit wire
  wire rx_in    = !loop ? rxd_s_r :
                  (!src ? txs_txd :
                  (dir ? txs_txd : txi_s_r));

  always @(posedge aclk)
  begin
    if (rst_i)
    begin
      rxd_m_r <= 1'b1; rxd_s_r <= 1'b1;
      txi_m_r <= 1'b1; txi_s_r <= 1'b1;
      rx_prev_r <= 1'b1;
      txd_o <= 1'b1; txd_oe <= 1'b0; rx_pin_used <= 1'b1;
    end
    else
    begin
      rxd_m_r     <= rxd_i;
      rxd_s_r     <= rxd_m_r;
      txi_m_r     <= txd_i;
      txi_s_r     <= txi_m_r;
      rx_prev_r   <= rx_in;
      txd_o       <= txs_txd;
      // Pin released when idle and disabled, or turned to input in single-wire
      txd_oe      <= (te | txs_busy) & ~(single & ~dir);
      rx_pin_used <= ~loop;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Bit clock, halted in light stop

  always @(posedge aclk)
  begin
    if (rst_i || !ce || (baud_r == 13'h0000))
    begin
      div_cnt_r <= 13'h0000;
      tick_r    <= 1'b0;
    end
    else if (div_cnt_r == (baud_r - 13'h0001))
    begin
      div_cnt_r <= 13'h0000;
      tick_r    <= 1'b1;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 13'h0001;
      tick_r    <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Shifters

  wire       rxs_tick;
  wire       rxs_val;
  wire       rxs_frame;
  wire       rxs_msb;
  wire       rxs_done;
  wire [8:0] rxs_data;
  wire       rxs_nf;
  wire       rxs_fe;
  wire       rxs_pf;

  uart_rx_shift u_rx
  (
    .aclk        (aclk),
    .rst         (rst_i | ~re),
    .tick16      (tick_r),
    .rx_in       (rx_in),
    .nine        (nine),
    .par_en      (ctrl1_r[`C1_PAR_EN]),
    .par_odd     (ctrl1_r[`C1_PAR_ODD]),
    .bit_tick_r  (rxs_tick),
    .bit_val_r   (rxs_val),
    .in_frame    (rxs_frame),
    .msb_set_r   (rxs_msb),
    .done_r      (rxs_done),
    .data_r      (rxs_data),
    .noise_r     (rxs_nf),
    .frame_err_r (rxs_fe),
    .par_err_r   (rxs_pf)
  );

  wire        tx_load  = te & ~txs_busy & (pre_pend_r | tx_full_r);
  wire [11:0] tx_frame = pre_pend_r ? 12'hFFF :
                         mk_frame(tx_buf_r, ctrl3_r[`C3_TX_NINTH], nine,
                                  ctrl1_r[`C1_PAR_EN], ctrl1_r[`C1_PAR_ODD]);

  uart_tx_shift u_tx
  (
    .aclk   (aclk),
    .rst    (rst_i),
    .tick16 (tick_r),
    .load   (tx_load),
    .frame  (tx_frame),
    .nbits  (char_len),
    .busy   (txs_busy),
    .txd_r  (txs_txd)
  );

////////////////////////////////////////////////////////////////////////////////
// Register bus: address and data are taken together, answer one cycle later

  wire wr_hs   = awready & awvalid;
  wire rd_hs   = arready & arvalid;
  wire wr_en   = wr_hs & wstrb[0];
  wire st_rd   = rd_hs & (araddr == `ADDR_STAT1);
  wire data_rd = rd_hs & (araddr == `ADDR_DATA);
  wire tx_wr   = wr_en & (awaddr == `ADDR_DATA);
  wire s2_wr   = wr_en & (awaddr == `ADDR_STAT2);
  wire wr_map  = (awaddr[7:5] == 3'h0) && (awaddr[1:0] == 2'h0);
  wire rd_map  = (araddr[7:5] == 3'h0) && (araddr[1:0] == 2'h0);

  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (araddr)
      `ADDR_BAUD:  rdata_nxt[12:0] = baud_r;
      `ADDR_CTRL1: rdata_nxt[7:0]  = ctrl1_r;
      `ADDR_CTRL2: rdata_nxt[7:0]  = {ctrl2_r[7:2], sleep_r, ctrl2_r[0]};
      `ADDR_STAT1: rdata_nxt[7:0]  = {~tx_full_r, tc_r, rx_full_flag_r, idle_r,
                                      or_r, nf_r, fe_r, pf_r};
      `ADDR_STAT2: rdata_nxt[7:0]  = {brk_r, edge_r, 2'b00, idle_rpt_r,
                                      2'b00, rxs_frame};
      `ADDR_CTRL3: rdata_nxt[7:0]  = {rx_ninth_r, ctrl3_r};
      `ADDR_DATA:  rdata_nxt[7:0]  = rx_data_r;
      `ADDR_CTRL4: rdata_nxt[1:0]  = ctrl4_r;
      default:     rdata_nxt       = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk)
  begin
    if (rst_i)
    begin
      awready <= 1'b0; wready <= 1'b0; bvalid <= 1'b0; bresp <= 2'h0;
      arready <= 1'b0; rvalid <= 1'b0; rdata <= 32'h0000_0000; rresp <= 2'h0;
    end
    else
    begin
      awready <= awvalid & wvalid & ~awready & ~bvalid & ce;
      wready  <= awvalid & wvalid & ~awready & ~bvalid & ce;
      arready <= arvalid & ~arready & ~rvalid & ce;
      if (wr_hs)
      begin
        bvalid <= 1'b1;
        bresp  <= wr_map ? 2'h0 : 2'h2;
      end
      else if (bready)
        bvalid <= 1'b0;
      if (rd_hs)
      begin
        rvalid <= 1'b1;
        rdata  <= rdata_nxt;
        rresp  <= rd_map ? 2'h0 : 2'h2;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Control registers

  always @(posedge aclk)
  begin
    if (rst_i)
    begin
      baud_r <= `BAUD_RST; ctrl1_r <= `CTRL_RST; ctrl2_r <= `CTRL_RST;
      ctrl3_r <= 7'h00; ctrl4_r <= 2'h0; idle_rpt_r <= 1'b0;
    end
    else if (wr_en)
    begin
      case (awaddr)
        `ADDR_BAUD:
        begin
          baud_r[7:0] <= wdata[7:0];
          if (wstrb[1])
            baud_r[12:8] <= wdata[12:8];
        end
        `ADDR_CTRL1: ctrl1_r    <= wdata[7:0];
        `ADDR_CTRL2: ctrl2_r    <= wdata[7:0];
        `ADDR_STAT2: idle_rpt_r <= wdata[`S2_IDLE_RPT];
        `ADDR_CTRL3: ctrl3_r    <= wdata[6:0];
        `ADDR_CTRL4: ctrl4_r    <= wdata[1:0];
        default:     ctrl4_r    <= ctrl4_r;
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Idle detection and wakeup

  wire idle_need = (idle_cnt_r == (char_len - 4'h1));
  wire idle_ev   = re & rxs_tick & rxs_val & idle_need &
                   ~(ctrl1_r[`C1_IDLE_TYP] & rxs_frame);
  wire idle_set  = idle_ev & idle_ok_r & (~sleep_r | idle_rpt_r);
  wire wake      = ctrl1_r[`C1_WAKE_SEL];

  always @(posedge aclk)
  begin
    if (rst_i)
      idle_cnt_r <= 4'h0;
    else if (rxs_tick)
    begin
      // Zero bits restart the count; type 1 also holds it through the frame
      if (!rxs_val || (ctrl1_r[`C1_IDLE_TYP] && rxs_frame))
        idle_cnt_r <= 4'h0;
      else if (idle_cnt_r != char_len)
        idle_cnt_r <= idle_cnt_r + 4'h1;
    end
  end

  always @(posedge aclk)
  begin
    if (rst_i)
      sleep_r <= 1'b0;
    else if (idle_ev && !wake)
      sleep_r <= 1'b0;
    else if (rxs_msb && wake)
      sleep_r <= 1'b0;
    else if (wr_en && (awaddr == `ADDR_CTRL2))
      sleep_r <= wdata[`C2_SLEEP];
  end

////////////////////////////////////////////////////////////////////////////////
// Status flags; a set in the same cycle as its clear wins

  wire       rx_take = rxs_done & ~sleep_r;
  wire       rx_ovr  = rx_take & rx_full_flag_r;
  wire       rx_load = rx_take & ~rx_full_flag_r;
  wire [5:0] clr     = data_rd ? arm_r : 6'h00;
  wire       edge_set = re & rx_prev_r & ~rx_in & ~sleep_r;
  wire       brk_set  = rx_load & rxs_fe & (rxs_data == 9'h000);

  always @(posedge aclk)
  begin
    if (rst_i)
    begin
      rx_full_flag_r <= 1'b0; idle_r <= 1'b0; or_r <= 1'b0; nf_r <= 1'b0;
      fe_r <= 1'b0; pf_r <= 1'b0; edge_r <= 1'b0; brk_r <= 1'b0;
      arm_r <= 6'h00; idle_ok_r <= 1'b1; rx_data_r <= 8'h00; rx_ninth_r <= 1'b0;
    end
    else
    begin
      rx_full_flag_r <= rx_load | (rx_full_flag_r & ~clr[4]);
      idle_r <= idle_set | (idle_r & ~clr[5]);
      or_r   <= rx_ovr | (or_r & ~clr[3]);
      nf_r   <= (rx_load & rxs_nf) | (nf_r & ~clr[2]);
      fe_r   <= (rx_load & rxs_fe) | (fe_r & ~clr[1]);
      pf_r   <= (rx_load & rxs_pf) | (pf_r & ~clr[0]);
      edge_r <= edge_set | (edge_r & ~(s2_wr & wdata[`S2_EDGE]));
      brk_r  <= brk_set | (brk_r & ~(s2_wr & wdata[`S2_BREAK]));
      if (st_rd)
        arm_r <= {idle_r, rx_full_flag_r, or_r, nf_r, fe_r, pf_r};
      else if (data_rd)
        arm_r <= 6'h00;
      // A long idle line reports once until a character arrives
      if (rx_load)
        idle_ok_r <= 1'b1;
      else if (idle_set)
        idle_ok_r <= 1'b0;
      if (rx_load)
      begin
        rx_data_r  <= rxs_data[7:0];
        rx_ninth_r <= rxs_data[8];
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Transmit buffer

  always @(posedge aclk)
  begin
    if (rst_i)
    begin
      tx_buf_r <= 8'h00; tx_full_r <= 1'b0; pre_pend_r <= 1'b0;
      te_prev_r <= 1'b0; tc_r <= 1'b1;
    end
    else
    begin
      te_prev_r  <= te;
      // Enabling the transmitter queues one idle character first
      pre_pend_r <= (te & ~te_prev_r) | (pre_pend_r & ~tx_load);
      tx_full_r  <= tx_wr | (tx_full_r & ~(tx_load & ~pre_pend_r));
      if (tx_wr)
        tx_buf_r <= wdata[7:0];
      tc_r <= ~tx_full_r & ~txs_busy & ~pre_pend_r & ~tx_load & ~tx_wr;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Requests

  always @(posedge aclk)
  begin
    if (rst_i)
    begin
      irq_tx <= 1'b0; irq_rx <= 1'b0; irq_err <= 1'b0; wakeup <= 1'b0;
    end
    else
    begin
      irq_tx  <= (~tx_full_r & ctrl2_r[`C2_EMPTY_IE]) |
                 (tc_r & ctrl2_r[`C2_TC_IE]);
      irq_rx  <= (rx_full_flag_r & ctrl2_r[`C2_FULL_IE]) | (idle_r & ctrl2_r[`C2_IDLE_IE]) |
                 (edge_r & ctrl4_r[`C4_EDGE_IE]) | (brk_r & ctrl4_r[`C4_BREAK_IE]);
      irq_err <= |({or_r, nf_r, fe_r, pf_r} & ctrl3_r[3:0]);
      // Edge logic keeps running while the bit clock is frozen
      wakeup  <= stop_light & edge_r & ctrl4_r[`C4_EDGE_IE];
    end
  end

endmodule
`default_nettype wire

// ---- dv/uart_core_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module uart_core_checker
(
  // Clock, reset, power
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stop_light,
  input wire logic stop_deep,
  // Bus handshakes
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // Pins and requests
  input wire logic txd_o,
  input wire logic irq_tx,
  input wire logic irq_rx,
  input wire logic irq_err,
  input wire logic wakeup
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////
  chk_wake_light: assert property
    (wakeup |-> $past(stop_light)) else $error("wakeup outside light stop");
  chk_deep_clears: assert property
    (stop_deep |=> !irq_tx && !irq_rx && !irq_err && txd_o) else $error("deep stop kept state");
  chk_light_frozen: assert property
    (stop_light && !awready && !arready |=> !awready && !arready) else $error("bus ran in stop");
  chk_aw_w_pair: assert property
    (awready |-> wready) else $error("write halves split");
  chk_b_follows: assert property
    (awready && !stop_deep |=> bvalid) else $error("no write response");
  chk_r_follows: assert property
    (arready && !stop_deep |=> rvalid) else $error("no read response");
  chk_b_retire: assert property
    (bvalid && bready |=> !bvalid) else $error("write response stuck");
  chk_r_retire: assert property
    (rvalid && rready |=> !rvalid) else $error("read response stuck");
endmodule
`default_nettype wire

// ---- dv/serial_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(parameter int BT = 16)
(
  // Clock
  input wire logic       aclk,
  // Lines
  input wire logic       line_in,
  output var logic       line_out,
  // Last character heard
  output var logic [8:0] got,
  output var logic       got_ok
);
  initial line_out = 1'b1;
  initial got_ok = 1'b0;
  // A stop level of 0 is a deliberate framing fault
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (BT) @(posedge aclk);
    end
    line_out <= 1'b1;
    repeat (BT) @(posedge aclk);
  endtask
  // Samples mid-bit; ninth sample is the stop bit
  always
  begin
    @(negedge line_in);
    got_ok <= 1'b0;
    repeat (BT / 2) @(posedge aclk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BT) @(posedge aclk);
      got[i] <= line_in;
    end
    got_ok <= 1'b1;
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready, stop_light, stop_deep;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, seed, x;
  logic [3:0]  wstrb;
  logic [1:0]  r;
  int          bad_count, comparisons;
  wire         awready, wready, bvalid, arready, rvalid, rxd_i, got_ok, txd_o, txd_oe;
  wire         rx_pin_used, irq_tx, irq_rx, irq_err, wakeup;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [8:0]   got;
  // Far device drives the shared wire once the block lets go; it idles high
  wire         txd_i = txd_oe ? txd_o : rxd_i;
  uart_core uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .rxd_i(rxd_i), .txd_i(txd_i), .txd_o(txd_o), .txd_oe(txd_oe), .rx_pin_used(rx_pin_used),
    .stop_light(stop_light), .stop_deep(stop_deep), .irq_tx(irq_tx), .irq_rx(irq_rx),
    .irq_err(irq_err), .wakeup(wakeup));
  serial_peer #(.BT(16)) peer (.aclk(aclk), .line_in(txd_o), .line_out(rxd_i), .got(got),
    .got_ok(got_ok));
  //////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(posedge aclk);
    while (!(awready && wready)) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    while (!bvalid) @(posedge aclk);
    chk("bresp", 32'h0, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    x = rdata;
    r = rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, string nm);
    rd(a);
    chk(nm, {24'h0, e}, x & {24'h0, m});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////
  always #12.5 aclk = ~aclk;
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    test_done();
  end
  initial
  begin
    aclk = 1'b0;
    {aresetn, awvalid, wvalid, arvalid, stop_light, stop_deep} = 6'h00;
    {bready, rready, wstrb} = 6'h3F;
    {awaddr, araddr, wdata} = 48'h0;
    seed = 32'h0001333A;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`ADDR_STAT1, 8'hC0, 8'hC0, "stat1 reset");
    rd(8'h20);
    chk("unmapped resp", 32'h2, {30'h0, r});
    wr(`ADDR_BAUD, 32'h1);
    wr(`ADDR_CTRL3, 32'h0F);
    wr(`ADDR_CTRL2, 32'h8C);
    repeat (3) @(posedge aclk);
    chk("irq_tx empty", 1, irq_tx);
    wr(`ADDR_CTRL2, 32'h4C);
    $display("test regs done");
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      wr(`ADDR_DATA, seed);
      repeat (3) @(posedge aclk);
      chk("irq_tx busy", 0, irq_tx);
      @(posedge got_ok);
      chk("tx char", {24'h1, seed[7:0]}, {23'h0, got});
    end
    repeat (40) @(posedge aclk);
    chk("irq_tx complete", 1, irq_tx);
    $display("test tx done");
    wr(`ADDR_CTRL2, 32'h2C);
    seed = lfsr(seed);
    peer.send(seed[7:0], 1'b1);
    chk("irq_rx full", 1, irq_rx);
    rc(`ADDR_STAT1, 8'h2F, 8'h20, "stat1 full");
    rc(`ADDR_DATA, 8'hFF, seed[7:0], "rx char");
    rc(`ADDR_STAT1, 8'h20, 8'h00, "full cleared");
    // Second character lost to overrun carries a framing fault
    peer.send(8'hA5, 1'b1);
    peer.send(8'h5A, 1'b0);
    chk("irq_err", 1, irq_err);
    rc(`ADDR_STAT1, 8'h2F, 8'h28, "stat1 overrun");
    rc(`ADDR_DATA, 8'hFF, 8'hA5, "kept char");
    peer.send(8'h5A, 1'b0);
    rc(`ADDR_STAT1, 8'h2F, 8'h22, "stat1 framing");
    rc(`ADDR_DATA, 8'hFF, 8'h5A, "framed char");
    $display("test rx done");
    wr(`ADDR_CTRL1, 32'h08);
    wr(`ADDR_CTRL2, 32'h2E);
    peer.send(8'h33, 1'b1);
    rc(`ADDR_STAT1, 8'h2F, 8'h00, "asleep flags");
    peer.send(8'hC3, 1'b1);
    rc(`ADDR_CTRL2, 8'h02, 8'h00, "woken");
    rc(`ADDR_STAT1, 8'h20, 8'h20, "mark full");
    rc(`ADDR_DATA, 8'hFF, 8'hC3, "mark char");
    wr(`ADDR_CTRL1, 32'h00);
    wr(`ADDR_CTRL2, 32'h2E);
    peer.send(8'h0F, 1'b1);
    rc(`ADDR_CTRL2, 8'h02, 8'h02, "still asleep");
    repeat (200) @(posedge aclk);
    rc(`ADDR_CTRL2, 8'h02, 8'h00, "idle woken");
    rc(`ADDR_STAT1, 8'h30, 8'h00, "no wake idle");
    wr(`ADDR_CTRL1, 32'h80);
    repeat (2) @(posedge aclk);
    chk("rx pin freed", 0, rx_pin_used);
    fork
      peer.send(8'h00, 1'b1);
    join_none
    wr(`ADDR_DATA, 32'h96);
    repeat (250) @(posedge aclk);
    rc(`ADDR_STAT1, 8'h20, 8'h20, "loop full");
    rc(`ADDR_DATA, 8'hFF, 8'h96, "loop char");
    wr(`ADDR_CTRL1, 32'hA0);
    repeat (2) @(posedge aclk);
    chk("pin input", 0, txd_oe);
    peer.send(8'h4B, 1'b1);
    rc(`ADDR_STAT1, 8'h20, 8'h20, "wire full");
    rc(`ADDR_DATA, 8'hFF, 8'h4B, "wire char");
    wr(`ADDR_CTRL1, 32'hB0);
    wr(`ADDR_CTRL3, 32'h6F);
    seed = lfsr(seed);
    wr(`ADDR_DATA, seed);
    repeat (250) @(posedge aclk);
    chk("pin driven", 1, txd_oe);
    rc(`ADDR_STAT1, 8'h20, 8'h20, "echo full");
    rc(`ADDR_CTRL3, 8'h80, 8'h80, "rx ninth");
    rc(`ADDR_DATA, 8'hFF, seed[7:0], "echo char");
    $display("test wake done");
    wr(`ADDR_CTRL1, 32'h00);
    wr(`ADDR_STAT2, 32'h40);
    rc(`ADDR_STAT2, 8'h40, 8'h00, "edge cleared");
    wr(`ADDR_CTRL4, 32'h01);
    stop_light <= 1'b1;
    peer.send(8'hF0, 1'b1);
    chk("wakeup", 1, wakeup);
    stop_light <= 1'b0;
    @(posedge aclk);
    rc(`ADDR_STAT2, 8'h40, 8'h40, "edge flag");
    rc(`ADDR_CTRL4, 8'h01, 8'h01, "light keeps");
    stop_deep <= 1'b1;
    repeat (2) @(posedge aclk);
    stop_deep <= 1'b0;
    @(posedge aclk);
    rc(`ADDR_CTRL2, 8'hFF, 8'h00, "deep loses");
    $display("test stop done");
    test_done();
  end
endmodule
bind uart_core uart_core_checker chk_i (.aclk(aclk), .aresetn(aresetn),
  .stop_light(stop_light), .stop_deep(stop_deep), .awready(awready), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arready(arready), .rvalid(rvalid), .rready(rready),
  .txd_o(txd_o), .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err), .wakeup(wakeup));
`default_nettype wire
